// [hdl/i2c_seq_pkg.sv]
// constants for the two-wire master sequencer with status flags
// assumes a 125 MHz system clock and a plain strobed register port
package i2c_seq_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_TX_DATA = 4'h2;
  localparam logic [3:0] ADDR_RX_DATA = 4'h3;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h5;
  localparam logic [3:0] ADDR_DIVIDER = 4'h6;
  // ****************
  // control fields
  // ****************
  localparam int CTL_START = 0;
  localparam int CTL_RESTART = 1;
  localparam int CTL_STOP = 2;
  localparam int CTL_RECEIVE = 3;
  localparam int CTL_ACK_SEQ = 4;
  localparam int CTL_ACK_VALUE = 5;
  // ****************
  // status fields
  // ****************
  localparam int STA_RX_FULL = 1;
  localparam int STA_TX_BUSY = 0;
  localparam int STA_OVERFLOW = 6;
  localparam int STA_SLAVE_ACK = 15;
  // ****************
  // interrupt fields
  // ****************
  localparam int IRQ_SEQ_DONE = 0;
  localparam int IRQ_RX_BYTE = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam int IRQ_NACK = 3;
  localparam int IRQ_WIDTH = 4;
  // ****************
  // timing and reset values
  // ****************
  localparam int CLOCK_MHZ = 125;
  localparam int QUARTER_NS = 2500;
  localparam int QUARTER_CYCLES = (QUARTER_NS * CLOCK_MHZ) / 1000;
  localparam logic [15:0] DIVIDER_RESET = 16'h0138;
  localparam logic [15:0] REG_RESET = 16'h0000;
  typedef enum {
    ST_IDLE, ST_START, ST_RESTART, ST_STOP, ST_TX, ST_RX, ST_ACK
  } seq_state_t;
endpackage

// [hdl/i2c_seq.sv]
// two-wire bus master sequencer, register port, status and interrupt
// assumes open-drain pads outside; the bus pins are asynchronous
`timescale 1ns/1ns
`default_nettype none
module i2c_seq
  import i2c_seq_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // bus pins, enable low while driving low
  input wire logic bus_clock_line_in,
  output logic bus_clock_line_out,
  output logic bus_clock_line_oe_n_out,
  input wire logic bus_data_line_in,
  output logic bus_data_line_out,
  output logic bus_data_line_oe_n_out,
  // interrupt
  output logic irq_out
);
  // ****************
  // state
  // ****************
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [5:0] control;
    logic slave_ack;
    logic overflow;
    logic [7:0] tx_data;
    logic tx_busy;
    logic [7:0] receive_buffer;
    logic rx_full;
    logic [7:0] receive_shift_register;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [15:0] divider;
    logic [15:0] count;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    seq_state_t state;
    logic scl_low;
    logic sda_low;
    logic [15:0] rdata;
    logic irq;
  } regs_t;

  regs_t r_reg;
  regs_t r_next;
  logic rst_n;
  logic tick;
  logic last_phase;
  logic [IRQ_WIDTH-1:0] ev;

  assign rst_n = r_reg.rst_sync[1];

  // ****************
  // next state
  // ****************
  // one pass: synchronisers, timer, engine, register port, interrupt
  always_comb begin
    r_next = r_reg;
    ev = '0;
    // ****************
    // synchronisers
    // ****************
    // bus lines are asynchronous; only the second flop feeds logic
    r_next.rst_sync = {r_reg.rst_sync[0], 1'b1};
    r_next.scl_sync = {r_reg.scl_sync[0], bus_clock_line_in};
    r_next.sda_sync = {r_reg.sda_sync[0], bus_data_line_in};
    // ****************
    // quarter bit timer
    // ****************
    // stretching holds it while the clock line is low
    // the hold only bites in the high phase, so a slow slave never loses a bit
    tick = (r_reg.count == 16'h0000);
    if (r_reg.state == ST_IDLE) begin
      r_next.count = r_reg.divider;
      tick = 1'b0;
    end else if (r_reg.phase == 2'd2 && !r_reg.scl_low && !r_reg.scl_sync[1]) begin
      tick = 1'b0;
    end else if (tick) begin
      r_next.count = r_reg.divider;
    end else begin
      r_next.count = r_reg.count - 16'h0001;
    end
    last_phase = tick && (r_reg.phase == 2'd3);
    if (tick) begin
      r_next.phase = r_reg.phase + 2'd1;
    end
    // ****************
    // sequence engine
    // ****************
    // limitation: no collision or arbitration check on the data line
    unique case (r_reg.state)
      ST_IDLE: begin
        r_next.phase = 2'd0;
        r_next.bit_cnt = 4'd0;
        // fixed priority only guards against double requests
        if (r_reg.control[CTL_START]) begin
          r_next.state = ST_START;
        end else if (r_reg.control[CTL_RESTART]) begin
          r_next.state = ST_RESTART;
        end else if (r_reg.control[CTL_STOP]) begin
          r_next.state = ST_STOP;
        end else if (r_reg.control[CTL_RECEIVE]) begin
          r_next.state = ST_RX;
        end else if (r_reg.control[CTL_ACK_SEQ]) begin
          r_next.state = ST_ACK;
        end else if (r_reg.tx_busy) begin
          r_next.state = ST_TX;
        end
      end
      ST_START: begin
        // data falls while clock high, then clock falls
        // the clock stays low, ready for the first bit
        if (tick && r_reg.phase == 2'd1) r_next.sda_low = 1'b1;
        if (tick && r_reg.phase == 2'd2) r_next.scl_low = 1'b1;
        if (last_phase) begin
          r_next.control[CTL_START] = 1'b0;
          ev[IRQ_SEQ_DONE] = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_RESTART: begin
        // release data, raise clock, then start again
        if (tick && r_reg.phase == 2'd0) r_next.sda_low = 1'b0;
        if (tick && r_reg.phase == 2'd1) r_next.scl_low = 1'b0;
        if (tick && r_reg.phase == 2'd2) r_next.sda_low = 1'b1;
        if (last_phase) begin
          r_next.scl_low = 1'b1;
          r_next.control[CTL_RESTART] = 1'b0;
          ev[IRQ_SEQ_DONE] = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_STOP: begin
        // data low, clock up, then data rises while clock high
        // both lines end released, so the bus is free
        if (tick && r_reg.phase == 2'd0) r_next.sda_low = 1'b1;
        if (tick && r_reg.phase == 2'd1) r_next.scl_low = 1'b0;
        if (tick && r_reg.phase == 2'd2) r_next.sda_low = 1'b0;
        if (last_phase) begin
          r_next.control[CTL_STOP] = 1'b0;
          ev[IRQ_SEQ_DONE] = 1'b1;
          r_next.state = ST_IDLE;
        end
      end
      ST_TX, ST_RX, ST_ACK: begin
        // one bit per four quarters: set data, clock up, sample, clock down
        if (tick && r_reg.phase == 2'd0) begin
          if (r_reg.state == ST_ACK) begin
            r_next.sda_low = !r_reg.control[CTL_ACK_VALUE];
          end else if (r_reg.state == ST_TX && r_reg.bit_cnt < 4'd8) begin
            r_next.sda_low = !r_reg.tx_data[7];
          end else begin
            r_next.sda_low = 1'b0;
          end
        end
        if (tick && r_reg.phase == 2'd1) r_next.scl_low = 1'b0;
        if (tick && r_reg.phase == 2'd2) begin
          if (r_reg.state == ST_RX) begin
            r_next.receive_shift_register = {r_reg.receive_shift_register[6:0], r_reg.sda_sync[1]};
          end else if (r_reg.state == ST_TX && r_reg.bit_cnt < 4'd8) begin
            r_next.tx_data = {r_reg.tx_data[6:0], 1'b0};
          end else if (r_reg.state == ST_TX) begin
            r_next.slave_ack = r_reg.sda_sync[1];
            ev[IRQ_NACK] = r_reg.sda_sync[1];
          end
        end
        if (last_phase) begin
          r_next.scl_low = 1'b1;
          r_next.bit_cnt = r_reg.bit_cnt + 4'd1;
          if (r_reg.state == ST_ACK) begin
            r_next.control[CTL_ACK_SEQ] = 1'b0;
            ev[IRQ_SEQ_DONE] = 1'b1;
            r_next.state = ST_IDLE;
          end else if (r_reg.state == ST_RX && r_reg.bit_cnt == 4'd7) begin
            r_next.control[CTL_RECEIVE] = 1'b0;
            ev[IRQ_RX_BYTE] = 1'b1;
            // an unread buffer keeps its older byte
            if (r_reg.rx_full) begin
              r_next.overflow = 1'b1;
              ev[IRQ_OVERFLOW] = 1'b1;
            end else begin
              r_next.receive_buffer = r_next.receive_shift_register;
              r_next.rx_full = 1'b1;
            end
            r_next.state = ST_IDLE;
          end else if (r_reg.state == ST_TX && r_reg.bit_cnt == 4'd8) begin
            r_next.tx_busy = 1'b0;
            ev[IRQ_SEQ_DONE] = 1'b1;
            r_next.state = ST_IDLE;
          end
        end
      end
    endcase
    // ****************
    // register port
    // ****************
    r_next.rdata = REG_RESET;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_CONTROL: r_next.rdata = {10'h000, r_reg.control};
        ADDR_STATUS: begin
          r_next.rdata[STA_SLAVE_ACK] = r_reg.slave_ack;
          r_next.rdata[STA_OVERFLOW] = r_reg.overflow;
          r_next.rdata[STA_RX_FULL] = r_reg.rx_full;
          r_next.rdata[STA_TX_BUSY] = r_reg.tx_busy;
        end
        ADDR_TX_DATA: r_next.rdata = {8'h00, r_reg.tx_data};
        ADDR_RX_DATA: begin
          r_next.rdata = {8'h00, r_reg.receive_buffer};
          // reading empties the buffer; a byte landing in this same cycle stays unread only if the buffer was empty, else it is dropped
          if (r_reg.rx_full || !ev[IRQ_RX_BYTE]) r_next.rx_full = 1'b0;
        end
        ADDR_IRQ_STATUS: r_next.rdata = {12'h000, r_reg.irq_status};
        ADDR_IRQ_MASK: r_next.rdata = {12'h000, r_reg.irq_mask};
        ADDR_DIVIDER: r_next.rdata = r_reg.divider;
        default: r_next.rdata = REG_RESET; // unmapped reads zero
      endcase
    end
    if (wr_in) begin
      unique case (addr_in)
        // enables only set; hardware alone clears them
        ADDR_CONTROL: begin
          r_next.control[CTL_ACK_VALUE] = wdata_in[CTL_ACK_VALUE];
          r_next.control[CTL_ACK_SEQ:CTL_START] = r_next.control[CTL_ACK_SEQ:CTL_START] | wdata_in[4:0];
        end
        // overflow cleared by writing zero; a same-cycle set still wins
        ADDR_STATUS: begin
          if (!wdata_in[STA_OVERFLOW] && !ev[IRQ_OVERFLOW]) r_next.overflow = 1'b0;
        end
        ADDR_TX_DATA: begin
          if (!r_reg.tx_busy) begin
            r_next.tx_data = wdata_in[7:0];
            r_next.tx_busy = 1'b1;
          end
        end
        ADDR_IRQ_STATUS: r_next.irq_status = r_reg.irq_status & ~wdata_in[IRQ_WIDTH-1:0];
        ADDR_IRQ_MASK: r_next.irq_mask = wdata_in[IRQ_WIDTH-1:0];
        ADDR_DIVIDER: r_next.divider = wdata_in;
        default: r_next.divider = r_next.divider;
      endcase
    end
    // ****************
    // interrupt
    // ****************
    // sticky events set after the clear so the set wins
    r_next.irq_status = r_next.irq_status | ev;
    r_next.irq = |(r_next.irq_status & r_next.irq_mask);
  end

  // ****************
  // registers
  // ****************
  // the whole state in one register
  // the inner reset branch holds everything while the release ripples through
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r_reg <= '0;
      r_reg.scl_sync <= 2'b11;
      r_reg.sda_sync <= 2'b11;
      r_reg.divider <= DIVIDER_RESET;
      r_reg.state <= ST_IDLE;
    end else if (!rst_n) begin
      r_reg <= '0;
      r_reg.rst_sync <= r_next.rst_sync;
      r_reg.scl_sync <= 2'b11;
      r_reg.sda_sync <= 2'b11;
      r_reg.divider <= DIVIDER_RESET;
      r_reg.state <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************
  // outputs
  // ****************
  // outputs straight from flops; pads pull low only
  // never driving high keeps a stretching slave safe from contention
  assign rdata_out = r_reg.rdata;
  assign bus_clock_line_out = 1'b0;
  assign bus_clock_line_oe_n_out = !r_reg.scl_low;
  assign bus_data_line_out = 1'b0;
  assign bus_data_line_oe_n_out = !r_reg.sda_low;
  assign irq_out = r_reg.irq;
endmodule
`default_nettype wire

// [dv/i2c_seq_assertions.sv]
// pin-level checks of the two-wire sequencer
// assumes a divider of at most 2: phases end within 400 clocks, receive frees data by clock five
`timescale 1ns/1ns
`default_nettype none
module i2c_seq_assertions
  import i2c_seq_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_n_in,
  // register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  // bus pulls
  input wire logic bus_clock_line_oe_n_out,
  input wire logic bus_data_line_oe_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // a control write that sets enable b
  sequence ctl_set(int b);
    wr_in && addr_in == ADDR_CONTROL && wdata_in[b];
  endsequence
  // data pulled low while the clock is released
  sequence data_falls_high;
    $fell(bus_data_line_oe_n_out) && bus_clock_line_oe_n_out;
  endsequence
  start_order_a: assert property (ctl_set(CTL_START) |=> bus_clock_line_oe_n_out [*4])
    else $error("clock pulled before start condition");
  start_cond_a: assert property (ctl_set(CTL_START) |-> ##[1:400] data_falls_high)
    else $error("no start condition");
  restart_cond_a: assert property (ctl_set(CTL_RESTART) |-> ##[1:400] data_falls_high)
    else $error("no repeated start");
  stop_cond_a: assert property (ctl_set(CTL_STOP) |->
    ##[1:400] ($rose(bus_data_line_oe_n_out) && bus_clock_line_oe_n_out))
    else $error("no stop condition");
  ack_drive_a: assert property (ctl_set(CTL_ACK_SEQ) ##0 !wdata_in[CTL_ACK_VALUE] |->
    ##[1:400] ($rose(bus_clock_line_oe_n_out) && !bus_data_line_oe_n_out))
    else $error("ack slot not driven low");
  nack_drive_a: assert property (ctl_set(CTL_ACK_SEQ) ##0 wdata_in[CTL_ACK_VALUE] |->
    ##[1:400] ($rose(bus_clock_line_oe_n_out) && bus_data_line_oe_n_out))
    else $error("nack slot not released");
  rx_release_a: assert property (ctl_set(CTL_RECEIVE) |-> ##5 bus_data_line_oe_n_out [*8])
    else $error("data pulled during receive");
  read_idle_a: assert property (rdata_out != 16'h0000 |-> $past(rd_in))
    else $error("read data outside its slot");
endmodule
bind i2c_seq i2c_seq_assertions i_i2c_seq_assertions (.mclk_in, .reset_n_in, .addr_in, .wdata_in,
  .wr_in, .rd_in, .rdata_out, .bus_clock_line_oe_n_out, .bus_data_line_oe_n_out);
`default_nettype wire

// [dv/i2c_slave_model.sv]
// behavioural two-wire slave: acks bytes, answers reads msb first
// assumes wire levels resolved with pull-ups by the bench
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model (
  // resolved wire levels
  input wire logic scl_in,
  input wire logic sda_in,
  // behaviour controls
  input wire logic nack_in,
  input wire logic stretch_in,
  input wire logic [7:0] byte_in,
  // pulls, low while driving
  output logic scl_oe_n_out,
  output logic sda_oe_n_out
);
  int pos = 9;
  logic first = 1'b0;
  logic rd_mode = 1'b0;
  initial begin
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  // start or restart opens an address byte
  always @(negedge sda_in) if (scl_in) begin
    pos = -1;
    first = 1'b1;
    rd_mode = 1'b0;
  end
  // stop frees the line
  always @(posedge sda_in) if (scl_in) begin
    pos = 9;
    sda_oe_n_out = 1'b1;
  end
  // next bit while the clock is low; idle (9) never drives
  always @(negedge scl_in) begin
    if (pos == 8) first = 1'b0;
    if (pos != 9) pos = (pos == 8) ? 0 : pos + 1;
    if (pos == 8) sda_oe_n_out = (first || !rd_mode) ? nack_in : 1'b1;
    else sda_oe_n_out = (pos < 8 && rd_mode && !first) ? byte_in[7 - pos] : 1'b1;
  end
  // direction bit, and the master's nack ends a read
  always @(posedge scl_in) begin
    if (first && pos == 7) rd_mode = sda_in;
    if (!first && rd_mode && pos == 8 && sda_in) pos = 9;
  end
  // slow answer: hold the clock low after each fall
  always @(negedge scl_in) if (stretch_in) begin
    scl_oe_n_out = 1'b0;
    #200 scl_oe_n_out = 1'b1;
  end
endmodule
`default_nettype wire

// [dv/i2c_master_sequencer_status_bench.sv]
// self-checking bench: register port, bus sequences, status, interrupt
// assumes pull-ups on both lines and a divider of 2
`timescale 1ns/1ns
`default_nettype none
module i2c_master_sequencer_status_bench;
  import i2c_seq_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, nack = 0, stretch = 0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, r;
  logic [7:0] tx_byte = 8'h00, exp_b;
  logic [31:0] seed = 32'h0000_5fab;
  wire logic [15:0] rdata;
  wire logic m_scl, m_sda, s_scl, s_sda, irq;
  wire logic scl = m_scl & s_scl;
  wire logic sda = m_sda & s_sda;
  int n_fail = 0, comparisons = 0;
  i2c_seq i_i2c_seq (.mclk_in(clk), .reset_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bus_clock_line_in(scl), .bus_clock_line_out(),
    .bus_clock_line_oe_n_out(m_scl), .bus_data_line_in(sda), .bus_data_line_out(),
    .bus_data_line_oe_n_out(m_sda), .irq_out(irq));
  i2c_slave_model i_i2c_slave_model (.scl_in(scl), .sda_in(sda), .nack_in(nack),
    .stretch_in(stretch), .byte_in(tx_byte), .scl_oe_n_out(s_scl), .sda_oe_n_out(s_sda));
  initial begin
    forever #4 clk = ~clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reset value of each index; unmapped ones read zero
  function logic [15:0] exp_reset(input logic [3:0] a);
    return (a == ADDR_DIVIDER) ? DIVIDER_RESET : REG_RESET;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  // launch, then poll the busy bit under a bound
  task automatic run(input logic [3:0] a, input logic [15:0] d, input logic [3:0] pa, input int b);
    int k = 0;
    wr_reg(a, d);
    r = 16'hffff;
    while (r[b] !== 1'b0 && k < 500) begin // next request waits for the clear
      rd_reg(pa, r);
      k++;
    end
    check(16'(r[b]), 16'h0000);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, well beyond the expected run
  initial begin
    #500_000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(4'h7, 16'(rnd())); // write to an unmapped index is dropped
    for (int a = 0; a < 8; a++) begin
      rd_reg(4'(a), r);
      check(r, exp_reset(4'(a)));
    end
    $display("reset values done");
    wr_reg(ADDR_DIVIDER, 16'h0002);
    wr_reg(ADDR_IRQ_MASK, 16'h000f);
    stretch <= 1'(rnd());
    run(ADDR_CONTROL, 16'h0001, ADDR_CONTROL, CTL_START);
    run(ADDR_TX_DATA, {8'h00, 8'(rnd()) & 8'hfe}, ADDR_STATUS, STA_TX_BUSY);
    rd_reg(ADDR_STATUS, r);
    check(16'(r[STA_SLAVE_ACK]), 16'h0000);
    nack <= 1'b1;
    run(ADDR_TX_DATA, {8'h00, 8'(rnd())}, ADDR_STATUS, STA_TX_BUSY);
    rd_reg(ADDR_STATUS, r);
    check(16'(r[STA_SLAVE_ACK]), 16'h0001);
    nack <= 1'b0;
    $display("master write done");
    tx_byte <= 8'(rnd());
    run(ADDR_CONTROL, 16'h0002, ADDR_CONTROL, CTL_RESTART);
    run(ADDR_TX_DATA, {8'h00, 8'(rnd()) | 8'h01}, ADDR_STATUS, STA_TX_BUSY);
    run(ADDR_CONTROL, 16'h0008, ADDR_CONTROL, CTL_RECEIVE);
    exp_b = tx_byte;
    rd_reg(ADDR_RX_DATA, r);
    check(r, {8'h00, exp_b});
    for (int i = 0; i < 2; i++) begin
      tx_byte <= 8'(rnd());
      run(ADDR_CONTROL, 16'h0010, ADDR_CONTROL, CTL_ACK_SEQ);
      if (i == 0) exp_b = tx_byte;
      run(ADDR_CONTROL, 16'h0008, ADDR_CONTROL, CTL_RECEIVE);
    end
    rd_reg(ADDR_STATUS, r);
    check(16'(r[STA_OVERFLOW]), 16'h0001);
    run(ADDR_CONTROL, 16'h0030, ADDR_CONTROL, CTL_ACK_SEQ);
    run(ADDR_CONTROL, 16'h0004, ADDR_CONTROL, CTL_STOP);
    rd_reg(ADDR_RX_DATA, r);
    check(r, {8'h00, exp_b});
    wr_reg(ADDR_STATUS, 16'h0000);
    rd_reg(ADDR_STATUS, r);
    check(16'(r[STA_OVERFLOW]), 16'h0000);
    $display("master read done");
    check(16'(irq), 16'h0001);
    rd_reg(ADDR_IRQ_STATUS, r);
    check(r, 16'h000f);
    wr_reg(ADDR_IRQ_STATUS, 16'h000f);
    rd_reg(ADDR_IRQ_STATUS, r);
    check(r, 16'h0000);
    check(16'(irq), 16'h0000);
    wr_reg(ADDR_IRQ_MASK, 16'h0000);
    run(ADDR_CONTROL, 16'h0001, ADDR_CONTROL, CTL_START);
    run(ADDR_CONTROL, 16'h0004, ADDR_CONTROL, CTL_STOP);
    check(16'(irq), 16'h0000);
    rd_reg(ADDR_IRQ_STATUS, r);
    check(r, 16'h0001);
    $display("interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
